// File: logic/tmr_consts.svh
// constants for the 8-bit timer with shared prescaler
// assumes inclusion by the timer top and the bench only
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
// ==========================================
// register byte addresses
`define TMR_ADDR_COUNT 12'h000
`define TMR_ADDR_OPTION 12'h004
`define TMR_ADDR_IRQ_STAT 12'h008
`define TMR_ADDR_IRQ_MASK 12'h00c
`define TMR_ADDR_CTRL 12'h010
`define TMR_ADDR_STATUS 12'h014
// ==========================================
// option word field positions
`define TMR_OPT_CS 5
`define TMR_OPT_SE 4
`define TMR_OPT_PSA 3
`define TMR_OPT_PS_HI 2
`define TMR_OPT_PS_LO 0
// ==========================================
// reset values
`define TMR_OPTION_RST 8'hff
`define TMR_COUNT_RST 8'h00
// ==========================================
// timing
`define TMR_CLK_MHZ 20
`define TMR_CYC_PER_INSTR 4
`define TMR_WR_INHIBIT 2
`endif

// File: logic/tmr_pkg.sv
// types for the 8-bit timer with shared prescaler
// assumes tmr_consts.svh is on the include path
package tmr_pkg;
  typedef struct packed {
    logic cs;
    logic se;
    logic prescaler_assign;
    logic [2:0] ps;
  } tmr_option_type;
  typedef enum logic [1:0] {
    TMR_PH1,
    TMR_PH2,
    TMR_PH3,
    TMR_PH4
  } tmr_phase_type;
endpackage : tmr_pkg

// File: logic/tmr_timer8.sv
// 8-bit timer/counter with prescaler shared with the watchdog, apb slave
// assumes pclk at 20 mhz, an instruction cycle of four pclk, async pin inputs
// Summary of operation
// - timer mode counts instruction cycles, undivided only when watchdog-assigned
// - count write blocks increments two instruction cycles
// - counter mode counts chosen edge of pin
// - source select one means counter, zero timer
// - one prescaler, timer or watchdog, never both
// - timer prescale ratios one to two..256
// - undivided timer only with watchdog assignment
// - prescaler count not software accessible
// - count write clears prescaler when timer-assigned
// - watchdog clear clears prescaler when watchdog-assigned
// - rollover ff to 00 sets overflow flag
// - overflow flag clears only by software
// - irq needs overflow flag and enable
// - sleep freezes counter, no overflow
// - external count sampled at phases two, four
`timescale 1ns/1ns
`include "tmr_consts.svh"
module tmr_timer8 #(
  parameter int PRE_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic sleep_mode,
  input wire logic watchdog_clear_instr,
  output logic wdt_tick,
  output logic irq
);
  // ==========================================
  // bus decode
  logic wr_en;
  logic addr_ok;
  // only the low byte lane holds register bits, so only its strobe counts
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign addr_ok = (paddr == `TMR_ADDR_COUNT) || (paddr == `TMR_ADDR_OPTION) ||
                   (paddr == `TMR_ADDR_IRQ_STAT) || (paddr == `TMR_ADDR_IRQ_MASK) ||
                   (paddr == `TMR_ADDR_CTRL) || (paddr == `TMR_ADDR_STATUS);
  logic wr_count;
  logic wr_option;
  assign wr_count = wr_en && (paddr == `TMR_ADDR_COUNT);
  assign wr_option = wr_en && (paddr == `TMR_ADDR_OPTION);
  logic wr_irq_stat;
  logic wr_irq_mask;
  assign wr_irq_stat = wr_en && (paddr == `TMR_ADDR_IRQ_STAT);
  assign wr_irq_mask = wr_en && (paddr == `TMR_ADDR_IRQ_MASK);
  // ==========================================
  // option register
  tmr_pkg::tmr_option_type option_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      option_ff <= tmr_pkg::tmr_option_type'(6'(`TMR_OPTION_RST));
    end else if (wr_option) begin
      option_ff <= tmr_pkg::tmr_option_type'(pwdata[5:0]);
    end
  end
  // ==========================================
  // instruction phase sequencer
  tmr_pkg::tmr_phase_type phase_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= tmr_pkg::TMR_PH1;
    end else begin
      unique case (phase_ff)
        tmr_pkg::TMR_PH1: phase_ff <= tmr_pkg::TMR_PH2;
        tmr_pkg::TMR_PH2: phase_ff <= tmr_pkg::TMR_PH3;
        tmr_pkg::TMR_PH3: phase_ff <= tmr_pkg::TMR_PH4;
        tmr_pkg::TMR_PH4: phase_ff <= tmr_pkg::TMR_PH1;
      endcase
    end
  end
  logic instr_tick;
  assign instr_tick = (phase_ff == tmr_pkg::TMR_PH4);
  // ==========================================
  // pin synchroniser and edge select
  logic pin_s1_ff;
  logic pin_s2_ff;
  logic pin_s3_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
      pin_s3_ff <= 1'b0;
    end else begin
      pin_s1_ff <= external_count_input;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end
  logic pin_edge;
  assign pin_edge = option_ff.se ? (pin_s3_ff && !pin_s2_ff) :
                    (!pin_s3_ff && pin_s2_ff);
  // source mux: pin edges or instruction cycles
  logic src_tick;
  assign src_tick = option_ff.cs ? pin_edge : instr_tick;
  // ==========================================
  // shared prescaler, never visible on the bus
  logic [PRE_W-1:0] pre_ff;
  logic pre_to_timer;
  logic pre_clr;
  logic pre_in;
  assign pre_to_timer = !option_ff.prescaler_assign;
  assign pre_clr = pre_to_timer ? wr_count : watchdog_clear_instr;
  assign pre_in = pre_to_timer ? src_tick : instr_tick;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= '0;
    end else if (pre_clr) begin
      pre_ff <= '0;
    end else if (pre_in && !(pre_to_timer && sleep_mode)) begin
      pre_ff <= pre_ff + 1'b1;
    end
  end
  // ratio 2^(n+1) to the timer, 2^n to the watchdog
  logic [PRE_W-1:0] pre_mask;
  logic pre_wrap;
  always_comb begin
    pre_mask = '0;
    for (int i = 0; i < PRE_W; i++) begin
      if (i <= int'(option_ff.ps) - (pre_to_timer ? 0 : 1)) begin
        pre_mask[i] = 1'b1;
      end
    end
  end
  // a clear in the wrap cycle wins, so no stale tick escapes it
  assign pre_wrap = pre_in && !pre_clr && ((pre_ff & pre_mask) == pre_mask);
  // ==========================================
  // counter-mode sampler: ticks land only on phases two and four
  logic raw_tick;
  logic sample_ph;
  logic pend_ff;
  assign raw_tick = pre_to_timer ? pre_wrap : src_tick;
  assign sample_ph = (phase_ff == tmr_pkg::TMR_PH2) || (phase_ff == tmr_pkg::TMR_PH4);
  // one pending tick only; a pin faster than two pclk per edge loses counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
    end else if (!option_ff.cs || sample_ph) begin
      pend_ff <= 1'b0;
    end else if (raw_tick) begin
      pend_ff <= 1'b1;
    end
  end
  logic count_tick;
  assign count_tick = option_ff.cs ? (sample_ph && (pend_ff || raw_tick)) : raw_tick;
  // ==========================================
  // count register and write inhibit
  logic [7:0] count_register_ff;
  logic [1:0] inhibit_ff;
  logic do_inc;
  // a count write overrides any increment and any rollover in its cycle
  assign do_inc = count_tick && (inhibit_ff == 2'h0) && !sleep_mode && !wr_count;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_ff <= 2'h0;
    end else if (wr_count) begin
      inhibit_ff <= 2'(`TMR_WR_INHIBIT);
    end else if (instr_tick && inhibit_ff != 2'h0) begin
      inhibit_ff <= inhibit_ff - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_register_ff <= `TMR_COUNT_RST;
    end else if (wr_count) begin
      count_register_ff <= pwdata[7:0];
    end else if (do_inc) begin
      count_register_ff <= count_register_ff + 8'h01;
    end
  end
  logic rollover;
  assign rollover = do_inc && (count_register_ff == 8'hff);
  // ==========================================
  // overflow flag, enable, irq
  logic overflow_flag_ff;
  logic overflow_irq_enable_ff;
  // set beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_ff <= 1'b0;
    end else if (rollover) begin
      overflow_flag_ff <= 1'b1;
    end else if (wr_irq_stat && pwdata[0]) begin
      overflow_flag_ff <= 1'b0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_ff <= 1'b0;
    end else if (wr_irq_mask) begin
      overflow_irq_enable_ff <= pwdata[0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= overflow_flag_ff && overflow_irq_enable_ff;
    end
  end
  // watchdog gets the divided instruction clock, or raw when timer owns it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_tick <= 1'b0;
    end else begin
      wdt_tick <= pre_to_timer ? instr_tick : pre_wrap;
    end
  end
  // ==========================================
  // read mux, taken in the setup cycle; prescaler deliberately absent
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0;
    unique case (paddr)
      `TMR_ADDR_COUNT: rd_word = {24'h0, count_register_ff};
      `TMR_ADDR_OPTION: rd_word = {26'h0, option_ff};
      `TMR_ADDR_IRQ_STAT: rd_word = {31'h0, overflow_flag_ff};
      `TMR_ADDR_IRQ_MASK: rd_word = {31'h0, overflow_irq_enable_ff};
      `TMR_ADDR_STATUS: rd_word = {30'h0, sleep_mode, inhibit_ff != 2'h0};
      default: rd_word = 32'h0;
    endcase
  end
  // ==========================================
  // apb answer, zero wait states
  logic setup_ph;
  assign setup_ph = psel && !penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !addr_ok;
      prdata <= (setup_ph && !pwrite) ? rd_word : 32'h0;
    end
  end
endmodule : tmr_timer8

// File: sim/tmr_pin_src.sv
// count pin source model: three slow toggles per go pulse
// assumes go is a one-cycle pulse; pin stands still between bursts
`timescale 1ns/1ns
module tmr_pin_src (
  input wire logic pclk,
  input wire logic go,
  output logic pin
);
  // ==========
  // toggle engine
  int left = 0;
  logic lvl = 1'b0;
  assign pin = lvl;
  // eight pclk per level, wide enough for the phase sampling
  always @(posedge pclk) begin
    if (go) begin
      left <= 24;
    end else if (left > 0) begin
      left <= left - 1;
      if (left % 8 == 1) begin
        lvl <= ~lvl;
      end
    end
  end
endmodule : tmr_pin_src

// File: sim/tmr_timer8_props.sv
// port checks for the timer
// assumes one pclk domain, bound into tmr_timer8
`timescale 1ns/1ns
module tmr_timer8_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_mode,
  input wire logic wdt_tick,
  input wire logic irq
);
  // ==========
  // properties
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RDY: assert property (psel && !penable |=> pready && penable)
    else $error("no ready after setup");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready too long");
  AST_IN_ACC: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UPPER: assert property (pready && !pwrite && !pslverr |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // flag only drops by a write, so irq may only fall two edges after one
  AST_HOLD_IRQ: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2))
    else $error("irq fell without a write");
  AST_SLEEP: assert property (sleep_mode && $past(sleep_mode, 2) && !$past(psel) &&
    !$past(psel, 2) |-> !$rose(irq)) else $error("irq rose in sleep");
  AST_TICK: assert property (wdt_tick |=> !wdt_tick [*3])
    else $error("watchdog ticks too close");
endmodule : tmr_timer8_props
bind tmr_timer8 tmr_timer8_props u_tmr_timer8_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleep_mode(sleep_mode), .wdt_tick(wdt_tick), .irq(irq));

// File: sim/tb_top.sv
// self-checking bench: apb tasks, pin model, rule scenarios
// assumes the checker binds itself; count-rate windows use read-to-read differences, except the write-inhibit one
`timescale 1ns/1ns
`include "tmr_consts.svh"
module tb_top;
  // ==========
  // harness
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic sleep_mode = 1'b0, wclr = 1'b0, go = 1'b0, pready, pslverr, pin, irq, err, wdt_tick;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v0, v1;
  int miscompares = 0, total_checks = 0, cyc = 0, wdt_n = 0, w0 = 0;
  always #25 pclk = ~pclk;
  tmr_timer8 u_tmr_timer8 (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_count_input(pin),
    .sleep_mode(sleep_mode), .watchdog_clear_instr(wclr), .wdt_tick(wdt_tick), .irq(irq));
  tmr_pin_src u_tmr_pin_src (.pclk(pclk), .go(go), .pin(pin));
  // idle edge after each transfer, so psel is never driven twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    v1 = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(v1, e);
  endtask : rdc
  // one-cycle watchdog clear; never called twice back to back
  task automatic wd_clear();
    wclr <= 1'b1;
    @(posedge pclk);
    wclr <= 1'b0;
  endtask : wd_clear
  always @(posedge pclk) begin
    if (wdt_tick === 1'b1) begin
      wdt_n <= wdt_n + 1;
    end
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ==========
  // scenarios
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`TMR_ADDR_OPTION, 32'h3f);
    rdc(`TMR_ADDR_CTRL, 32'h0);
    xfer(1'b0, 12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, `TMR_ADDR_OPTION, 32'h08);
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
    v0 = v1;
    repeat (37) @(posedge pclk);
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
    chk(v1 - v0, 32'h0a);
    for (int n = 0; n < 8; n++) begin
      xfer(1'b1, `TMR_ADDR_OPTION, 32'(n));
      xfer(1'b1, `TMR_ADDR_COUNT, 32'h0);
      repeat (12) @(posedge pclk);
      xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
      v0 = v1;
      repeat ((32 << n) - 3) @(posedge pclk);
      xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
      chk(v1 - v0, 32'h4);
    end
    // forty edges between write and read sample: ten boundaries, two blocked
    xfer(1'b1, `TMR_ADDR_OPTION, 32'h08);
    xfer(1'b1, `TMR_ADDR_COUNT, 32'h10);
    repeat (39) @(posedge pclk);
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
    chk(v1, 32'h18);
    xfer(1'b1, `TMR_ADDR_IRQ_MASK, 32'h0);
    xfer(1'b1, `TMR_ADDR_COUNT, 32'hfd);
    repeat (40) @(posedge pclk);
    rdc(`TMR_ADDR_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `TMR_ADDR_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    repeat (100) @(posedge pclk);
    rdc(`TMR_ADDR_IRQ_STAT, 32'h1);
    xfer(1'b1, `TMR_ADDR_IRQ_STAT, 32'h1);
    rdc(`TMR_ADDR_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, `TMR_ADDR_COUNT, 32'hfe);
    sleep_mode <= 1'b1;
    repeat (100) @(posedge pclk);
    rdc(`TMR_ADDR_COUNT, 32'hfe);
    rdc(`TMR_ADDR_IRQ_STAT, 32'h0);
    sleep_mode <= 1'b0;
    // three toggles give two edges of the chosen kind, one of the other
    for (int e = 0; e < 2; e++) begin
      xfer(1'b1, `TMR_ADDR_OPTION, 32'h28 | 32'(e << 4));
      xfer(1'b1, `TMR_ADDR_COUNT, 32'h0);
      repeat (12) @(posedge pclk);
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (60) @(posedge pclk);
      rdc(`TMR_ADDR_COUNT, 32'h2);
    end
    // watchdog to timer: clear first, then one option write at 1:16
    wd_clear();
    xfer(1'b1, `TMR_ADDR_OPTION, 32'h03);
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
    v0 = v1;
    repeat (253) @(posedge pclk);
    xfer(1'b0, `TMR_ADDR_COUNT, 32'h0);
    chk(v1 - v0, 32'h4);
    w0 = wdt_n;
    repeat (40) @(posedge pclk);
    chk(32'(wdt_n - w0), 32'ha);
    // timer to watchdog in the safe order, ending at 1:32
    wd_clear();
    xfer(1'b1, `TMR_ADDR_COUNT, 32'h0);
    xfer(1'b1, `TMR_ADDR_OPTION, 32'h0b);
    wd_clear();
    xfer(1'b1, `TMR_ADDR_OPTION, 32'h0d);
    w0 = wdt_n;
    repeat (512) @(posedge pclk);
    chk(32'(wdt_n - w0), 32'h4);
    // a clear restarts the watchdog share: first tick 32 boundaries later
    wd_clear();
    @(posedge pclk);
    w0 = wdt_n;
    repeat (124) @(posedge pclk);
    chk(32'(wdt_n - w0), 32'h0);
    repeat (5) @(posedge pclk);
    chk(32'(wdt_n - w0), 32'h1);
    give_verdict();
  end
endmodule : tb_top
